//--- design/ident_filter.sv
`timescale 1ns/1ps
`default_nettype none

module ident_filter
	import vid_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw pins
	input wire logic [7:0] pins,
	// Filtered code
	output logic [7:0] code,
	output logic change,
	output logic update
);

	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	logic [7:0] s3_reg;
	logic [7:0] code_reg;
	logic [5:0] ignore_reg;
	logic change_reg;
	logic update_reg;

	// ----------------------------------------
	// Change detect and ignore window
	// ----------------------------------------
	wire raw_change = (s2_reg != s3_reg);
	wire window_end = (ignore_reg == 6'h01) && !raw_change;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
			s3_reg <= 8'h00;
			code_reg <= IDENT_RST_CODE;
			ignore_reg <= 6'h00;
			change_reg <= 1'b0;
			update_reg <= 1'b0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			change_reg <= raw_change;
			update_reg <= window_end;
			// Skewed bits keep restarting the window
			if (raw_change) begin
				ignore_reg <= IGNORE_CYCLES;
			end else if (ignore_reg != 6'h00) begin
				ignore_reg <= ignore_reg - 6'h01;
			end
			if (window_end) begin
				code_reg <= s3_reg;
			end
		end
	end

	assign code = code_reg;
	assign change = change_reg;
	assign update = update_reg;

endmodule : ident_filter

`default_nettype wire

//--- design/vid_ctrl_pkg.sv
package vid_ctrl_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_TARGET_CODE = 8'h21;
	localparam logic [7:0] ADDR_PHASE_CFG = 8'hD1;
	localparam logic [7:0] ADDR_REG_CFG_A = 8'hD2;
	localparam logic [7:0] ADDR_REG_CFG_B = 8'hD3;
	localparam logic [7:0] ADDR_TRANSITION = 8'hD6;
	localparam logic [7:0] ADDR_TRIM = 8'hDB;
	localparam logic [7:0] ADDR_CAL = 8'hDC;
	localparam logic [7:0] ADDR_GOOD_UPPER = 8'hE0;
	localparam logic [7:0] ADDR_GOOD_LOWER = 8'hE1;
	localparam logic [7:0] ADDR_STATUS = 8'hF0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_TARGET_CODE = 8'h00;
	localparam logic [7:0] RST_PHASE_CFG = 8'h03;
	localparam logic [7:0] RST_REG_CFG = 8'h00;
	localparam logic [7:0] RST_TRANSITION = 8'h02;
	localparam logic [7:0] RST_OFFSET = 8'h00;
	localparam logic [7:0] RST_GOOD_UPPER = 8'h00;
	localparam logic [7:0] RST_GOOD_LOWER = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SRC_SEL_BIT = 3;
	localparam int OFFSET_SIGN_BIT = 5;
	localparam int OFFSET_MAG_MSB = 4;
	localparam int RATE_MSB = 2;
	localparam int UPPER_MSB = 1;
	localparam int LOWER_MSB = 2;
	localparam int LP_COUNT_LSB = 6;
	localparam int NORMAL_COUNT_MSB = 1;

	// ----------------------------------------
	// Identification and phase-count codes of note
	// ----------------------------------------
	localparam logic [7:0] IDENT_OFF_CODE = 8'h00;
	localparam logic [7:0] IDENT_NO_CPU_CODE = 8'hFF;
	localparam logic [7:0] IDENT_RST_CODE = 8'h00;
	localparam logic [1:0] LP_TWO_PHASE_CODE = 2'b01;

	// ----------------------------------------
	// Voltages, in microvolts, and slew rates, in V/ms
	// ----------------------------------------
	localparam int STEP_UV = 6250;
	localparam int OFFSET_MAX_UV = 193750;
	localparam logic [7:0] OFFSET_MAX_STEPS = 8'(OFFSET_MAX_UV / STEP_UV);
	localparam int UPPER_BASE_UV = 300000;
	localparam int UPPER_STEP_UV = 50000;
	localparam int LOWER_BASE_UV = 500000;
	localparam int LOWER_STEP_UV = 50000;
	localparam int CLAMP_RELEASE_UV = 300000;
	localparam logic [11:0] CLAMP_RELEASE_STEPS = 12'(CLAMP_RELEASE_UV / STEP_UV);
	localparam int RATE_BASE_VPMS = 1;
	localparam int RATE_STEP_VPMS = 2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int IGNORE_NS = 200;
	localparam logic [5:0] IGNORE_CYCLES = 6'((IGNORE_NS * CLK_MHZ + 999) / 1000);
	localparam int BLANK_US = 100;
	localparam int BLANK_CYCLES_DEF = BLANK_US * CLK_MHZ;
	localparam int OFF_CONFIRM_US = 5;
	localparam logic [9:0] OFF_CONFIRM_CYCLES = 10'(OFF_CONFIRM_US * CLK_MHZ);
	localparam int TURN_ON_DELAY_US = 1000;
	localparam int TURN_ON_DELAY_DEF = TURN_ON_DELAY_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SOFTSTART,
		ST_DELAY,
		ST_RUN,
		ST_SHUTDOWN
	} ctrl_state_type;

endpackage : vid_ctrl_pkg

//--- design/vid_target_and_power_good_control.sv
`timescale 1ns/1ps
`default_nettype none

module vid_target_and_power_good_control
	import vid_ctrl_pkg::*;
#(
	parameter logic [17:0] BLANK_CYCLES = 18'(BLANK_CYCLES_DEF),
	parameter logic [17:0] TURN_ON_DELAY = 18'(TURN_ON_DELAY_DEF)
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// Processor pins
	input wire logic [7:0] IDENT_PINS,
	input wire logic LOW_POWER_STATE_N,
	// Front-end status
	input wire logic ENABLE,
	input wire logic SUPPLY_OK,
	input wire logic [11:0] OUT_LEVEL,
	input wire logic LOAD_STEP_UP,
	input wire logic LOAD_RELEASE,
	// Regulator outputs
	output logic [11:0] TARGET_LEVEL,
	output logic [3:0] PHASE_ENABLE,
	output logic BASE_PHASE_DISABLE_N,
	output logic SWITCHED_PHASE_DISABLE_N,
	output logic TRANSIENT_DETECT_OUT,
	output logic CLAMP_ACTIVE,
	output logic CONTROLLER_SHUTDOWN,
	// Power-good open-drain pin
	output logic POWER_GOOD_OUT_O,
	output logic POWER_GOOD_OUT_OE
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic signed [6:0] sm_to_signed(input logic [7:0] f);
		logic [6:0] m;
		m = {2'b00, f[OFFSET_MAG_MSB:0]};
		return f[OFFSET_SIGN_BIT] ? -$signed(m) : $signed(m);
	endfunction : sm_to_signed

	function automatic logic [11:0] upper_steps(input logic [1:0] c);
		return 12'((UPPER_BASE_UV - int'(c) * UPPER_STEP_UV) / STEP_UV);
	endfunction : upper_steps

	function automatic logic [11:0] lower_steps(input logic [2:0] c);
		return 12'((LOWER_BASE_UV - int'(c) * LOWER_STEP_UV) / STEP_UV);
	endfunction : lower_steps

	// Least spacing between 6.25 mV steps, rounded up
	function automatic logic [10:0] slew_period(input logic [2:0] c);
		int r;
		r = RATE_BASE_VPMS + RATE_STEP_VPMS * int'(c);
		return 11'((STEP_UV * CLK_MHZ + r * 1000 - 1) / (r * 1000));
	endfunction : slew_period

	function automatic logic [3:0] normal_mask(input logic [2:0] n);
		return 4'((5'b00001 << n) - 5'b00001);
	endfunction : normal_mask

	function automatic logic [3:0] lp_mask(input logic [2:0] n, input logic two);
		logic [3:0] m;
		m = 4'b0001;
		if (two && n >= 3'd2) begin
			m = m | 4'(5'b00001 << (n >> 1));
		end
		return m;
	endfunction : lp_mask

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [11:0] out1_reg;
	logic [11:0] out2_reg;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			out1_reg <= 12'h000;
			out2_reg <= 12'h000;
		end else begin
			sync1_reg <= {LOAD_RELEASE, LOAD_STEP_UP, LOW_POWER_STATE_N, SUPPLY_OK, ENABLE};
			sync2_reg <= sync1_reg;
			out1_reg <= OUT_LEVEL;
			out2_reg <= out1_reg;
		end
	end

	wire en_ok = sync2_reg[0] & sync2_reg[1];
	wire low_power = !sync2_reg[2];
	wire step_up = sync2_reg[3];
	wire release_seen = sync2_reg[4];

	// ----------------------------------------
	// Identification input filter
	// ----------------------------------------
	logic [7:0] ident_code;
	logic ident_change;

	ident_filter u_ident (
		.clk(CLK),
		.rst_n(RST_N),
		.pins(IDENT_PINS),
		.code(ident_code),
		.change(ident_change),
		.update()
	);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] target_code_reg;
	logic [7:0] phase_count_config_reg;
	logic [7:0] regulator_config_a_reg;
	logic [7:0] regulator_config_b_reg;
	logic [7:0] transition_rate_reg;
	logic [7:0] output_trim_offset_reg;
	logic [7:0] output_cal_offset_reg;
	logic [7:0] good_upper_limit_reg;
	logic [7:0] good_lower_limit_reg;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			target_code_reg <= RST_TARGET_CODE;
			phase_count_config_reg <= RST_PHASE_CFG;
			regulator_config_a_reg <= RST_REG_CFG;
			regulator_config_b_reg <= RST_REG_CFG;
			transition_rate_reg <= RST_TRANSITION;
			output_trim_offset_reg <= RST_OFFSET;
			output_cal_offset_reg <= RST_OFFSET;
			good_upper_limit_reg <= RST_GOOD_UPPER;
			good_lower_limit_reg <= RST_GOOD_LOWER;
		end else if (REG_WR) begin
			case (REG_ADDR)
				ADDR_TARGET_CODE: target_code_reg <= REG_WDATA;
				ADDR_PHASE_CFG: phase_count_config_reg <= REG_WDATA;
				ADDR_REG_CFG_A: regulator_config_a_reg <= REG_WDATA;
				ADDR_REG_CFG_B: regulator_config_b_reg <= REG_WDATA;
				ADDR_TRANSITION: transition_rate_reg <= REG_WDATA;
				ADDR_TRIM: output_trim_offset_reg <= REG_WDATA;
				ADDR_CAL: output_cal_offset_reg <= REG_WDATA;
				ADDR_GOOD_UPPER: good_upper_limit_reg <= REG_WDATA;
				ADDR_GOOD_LOWER: good_lower_limit_reg <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Target selection and offset
	// ----------------------------------------
	// Both copies must be set, so one stray write cannot select the register source; clearing either one returns to the pins
	wire src_prog = regulator_config_a_reg[SRC_SEL_BIT] & regulator_config_b_reg[SRC_SEL_BIT];
	wire [7:0] base_code = src_prog ? target_code_reg : ident_code;

	wire signed [6:0] trim_s = sm_to_signed(output_trim_offset_reg);
	wire signed [6:0] cal_s = sm_to_signed(output_cal_offset_reg);
	wire signed [7:0] sum_s = 8'(trim_s) + 8'(cal_s);
	wire signed [7:0] max_s = $signed(OFFSET_MAX_STEPS);
	wire signed [7:0] offset_s = (sum_s > max_s) ? max_s :
		(sum_s < -max_s) ? -max_s : sum_s;
	wire signed [13:0] final_s = $signed({6'h00, base_code}) + 14'(offset_s);
	wire [11:0] final_level = final_s[13] ? 12'h000 : final_s[11:0];

	// ----------------------------------------
	// Control state and timers
	// ----------------------------------------
	ctrl_state_type state_reg;
	ctrl_state_type state_next;
	logic [11:0] level_reg;
	logic [10:0] slew_cnt_reg;
	logic [17:0] blank_cnt_reg;
	logic [17:0] delay_cnt_reg;
	logic [9:0] off_cnt_reg;

	wire active = (state_reg == ST_SOFTSTART) || (state_reg == ST_DELAY) || (state_reg == ST_RUN);
	wire at_target = (level_reg == final_level);
	wire off_seen = !src_prog && (ident_code == IDENT_OFF_CODE);
	wire off_confirmed = (off_cnt_reg == OFF_CONFIRM_CYCLES);
	wire delay_done = (delay_cnt_reg == TURN_ON_DELAY);
	wire blanked = (blank_cnt_reg != 18'h00000);
	wire slew_tick = (slew_cnt_reg == 11'h000);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: if (en_ok) state_next = ST_SOFTSTART;
			ST_SOFTSTART: if (at_target) state_next = ST_DELAY;
			ST_DELAY: if (delay_done) state_next = ST_RUN;
			ST_RUN: state_next = ST_RUN;
			ST_SHUTDOWN: state_next = ST_SHUTDOWN;
			default: state_next = ST_OFF;
		endcase
		if (active && off_confirmed) begin
			state_next = ST_SHUTDOWN;
		end
		// Shutdown latches until enable or supply OK goes low
		if (!en_ok) begin
			state_next = ST_OFF;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// One 6.25 mV step per slew period, both for soft-start and transitions
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			level_reg <= 12'h000;
			slew_cnt_reg <= 11'h000;
		end else if (!active) begin
			level_reg <= 12'h000;
			slew_cnt_reg <= 11'h000;
		end else if (!slew_tick) begin
			slew_cnt_reg <= slew_cnt_reg - 11'h001;
		end else if (!at_target) begin
			slew_cnt_reg <= slew_period(transition_rate_reg[RATE_MSB:0]) - 11'h001;
			level_reg <= (level_reg < final_level) ? level_reg + 12'h001 : level_reg - 12'h001;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			blank_cnt_reg <= 18'h00000;
			delay_cnt_reg <= 18'h00000;
			off_cnt_reg <= 10'h000;
		end else begin
			if (ident_change) begin
				blank_cnt_reg <= BLANK_CYCLES;
			end else if (blanked) begin
				blank_cnt_reg <= blank_cnt_reg - 18'h00001;
			end
			if (state_reg != ST_DELAY) begin
				delay_cnt_reg <= 18'h00000;
			end else if (!delay_done) begin
				delay_cnt_reg <= delay_cnt_reg + 18'h00001;
			end
			if (!off_seen) begin
				off_cnt_reg <= 10'h000;
			end else if (!off_confirmed) begin
				off_cnt_reg <= off_cnt_reg + 10'h001;
			end
		end
	end

	// ----------------------------------------
	// Power-good window and clamp
	// ----------------------------------------
	wire [11:0] upper = upper_steps(good_upper_limit_reg[UPPER_MSB:0]);
	wire [11:0] lower = lower_steps(good_lower_limit_reg[LOWER_MSB:0]);
	wire signed [13:0] tgt_s = $signed({2'b00, level_reg});
	wire signed [13:0] out_s = $signed({2'b00, out2_reg});
	wire signed [13:0] hi_s = tgt_s + $signed({2'b00, upper});
	wire signed [13:0] lo_s = tgt_s - $signed({2'b00, lower});
	wire window_ok = (out_s <= hi_s) && (out_s >= lo_s);
	wire over_trip = (out_s > hi_s);
	wire no_cpu = !src_prog && (ident_code == IDENT_NO_CPU_CODE);

	logic good_reg;
	logic clamp_reg;

	// While blanked the last verdict is held rather than forced either way
	wire good_next = (state_reg == ST_RUN) && en_ok && !no_cpu &&
		(blanked ? good_reg : window_ok);
	wire clamp_next = active && (clamp_reg ? (out2_reg >= CLAMP_RELEASE_STEPS) :
		(over_trip && !blanked));

	// ----------------------------------------
	// Phase management
	// ----------------------------------------
	wire [2:0] normal_n = 3'({1'b0, phase_count_config_reg[NORMAL_COUNT_MSB:0]}) + 3'd1;
	wire lp_two = (phase_count_config_reg[LP_COUNT_LSB+1:LP_COUNT_LSB] == LP_TWO_PHASE_CODE);
	// A load step overrides shedding so the shed phases come back, one per cycle
	wire shed = low_power && !step_up;
	wire [3:0] want_mask = (!active || clamp_reg) ? 4'h0 :
		shed ? lp_mask(normal_n, lp_two) : normal_mask(normal_n);
	wire [3:0] keep = PHASE_ENABLE & want_mask;
	wire [3:0] missing = want_mask & ~PHASE_ENABLE;
	wire [3:0] phase_next = keep | (missing & (~missing + 4'h1));

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			good_reg <= 1'b0;
			clamp_reg <= 1'b0;
			PHASE_ENABLE <= 4'h0;
			BASE_PHASE_DISABLE_N <= 1'b0;
			SWITCHED_PHASE_DISABLE_N <= 1'b0;
			TRANSIENT_DETECT_OUT <= 1'b0;
			TARGET_LEVEL <= 12'h000;
			CONTROLLER_SHUTDOWN <= 1'b0;
			CLAMP_ACTIVE <= 1'b0;
			POWER_GOOD_OUT_OE <= 1'b1;
		end else begin
			good_reg <= good_next;
			clamp_reg <= clamp_next;
			PHASE_ENABLE <= phase_next;
			BASE_PHASE_DISABLE_N <= active;
			SWITCHED_PHASE_DISABLE_N <= active && !shed;
			TRANSIENT_DETECT_OUT <= active && release_seen;
			TARGET_LEVEL <= level_reg;
			CONTROLLER_SHUTDOWN <= (state_reg == ST_SHUTDOWN);
			CLAMP_ACTIVE <= clamp_next;
			// Open drain: pull low whenever power is not good
			POWER_GOOD_OUT_OE <= !good_next;
		end
	end

	assign POWER_GOOD_OUT_O = 1'b0;

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	wire [7:0] status = {state_reg, 1'b0, shed, blanked, clamp_reg, good_reg};
	wire [7:0] rd_mux =
		(REG_ADDR == ADDR_TARGET_CODE) ? target_code_reg :
		(REG_ADDR == ADDR_PHASE_CFG) ? phase_count_config_reg :
		(REG_ADDR == ADDR_REG_CFG_A) ? regulator_config_a_reg :
		(REG_ADDR == ADDR_REG_CFG_B) ? regulator_config_b_reg :
		(REG_ADDR == ADDR_TRANSITION) ? transition_rate_reg :
		(REG_ADDR == ADDR_TRIM) ? output_trim_offset_reg :
		(REG_ADDR == ADDR_CAL) ? output_cal_offset_reg :
		(REG_ADDR == ADDR_GOOD_UPPER) ? good_upper_limit_reg :
		(REG_ADDR == ADDR_GOOD_LOWER) ? good_lower_limit_reg :
		(REG_ADDR == ADDR_STATUS) ? status : 8'h00;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rd_mux;
			end
		end
	end

endmodule : vid_target_and_power_good_control

`default_nettype wire

//--- sim/host_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_pins_model (
	// Clock
	input wire logic clk,
	// Requested code
	input wire logic [7:0] want_code,
	// Processor pins
	output logic [7:0] pins
);
	// One bit moves per cycle: skew shows transient codes to the filter
	logic [7:0] diff;
	logic [7:0] low_bit;
	assign diff = want_code ^ pins;
	assign low_bit = diff & (~diff + 8'h01);
	initial pins = 8'h40;
	always @(negedge clk) begin
		pins <= pins ^ low_bit;
	end
endmodule : host_pins_model

`default_nettype wire

//--- sim/vid_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module vid_ctrl_properties
	import vid_ctrl_pkg::*;
#(
	parameter logic [17:0] BLANK_CYCLES = 18'h00032
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Inputs watched
	input wire logic [7:0] IDENT_PINS,
	input wire logic LOW_POWER_STATE_N,
	input wire logic ENABLE,
	input wire logic SUPPLY_OK,
	input wire logic LOAD_STEP_UP,
	// Outputs watched
	input wire logic [11:0] TARGET_LEVEL,
	input wire logic [3:0] PHASE_ENABLE,
	input wire logic BASE_PHASE_DISABLE_N,
	input wire logic SWITCHED_PHASE_DISABLE_N,
	input wire logic CONTROLLER_SHUTDOWN,
	input wire logic POWER_GOOD_OUT_OE
);
	// ----
	// Helpers
	// ----
	logic [3:0] en_hist_reg;
	logic [7:0] pins_last_reg;
	logic [15:0] same_cnt_reg;
	logic [15:0] same_cnt_next;
	logic steady_ok;
	// Saturates so a long idle never wraps back under a threshold
	assign same_cnt_next = (IDENT_PINS != pins_last_reg) ? 16'h0000 :
		(same_cnt_reg == 16'hFFFF) ? same_cnt_reg : same_cnt_reg + 16'h0001;
	assign steady_ok = (&en_hist_reg) && ENABLE && SUPPLY_OK && !CONTROLLER_SHUTDOWN;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			en_hist_reg <= 4'h0;
			pins_last_reg <= 8'h00;
			same_cnt_reg <= 16'h0000;
		end else begin
			en_hist_reg <= {en_hist_reg[2:0], ENABLE && SUPPLY_OK};
			pins_last_reg <= IDENT_PINS;
			same_cnt_reg <= same_cnt_next;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// ----
	// Properties
	// ----
	good_enable_off_a: assert property ((!ENABLE)[*5] |-> POWER_GOOD_OUT_OE)
		else $error("power good not low with enable low");
	enable_phases_off_a: assert property ((!ENABLE)[*5] |->
		PHASE_ENABLE == 4'h0 && !BASE_PHASE_DISABLE_N)
		else $error("phases run with enable low");
	lockout_off_a: assert property ((!SUPPLY_OK)[*5] |-> PHASE_ENABLE == 4'h0 &&
		!BASE_PHASE_DISABLE_N && !SWITCHED_PHASE_DISABLE_N && POWER_GOOD_OUT_OE)
		else $error("outputs active under supply lockout");
	shed_low_a: assert property ((!LOW_POWER_STATE_N && !LOAD_STEP_UP)[*6] |->
		!SWITCHED_PHASE_DISABLE_N)
		else $error("switched phases not disabled in low power");
	no_cpu_good_a: assert property (IDENT_PINS == IDENT_NO_CPU_CODE &&
		same_cnt_reg > 16'(BLANK_CYCLES) + 16'h0040 |-> POWER_GOOD_OUT_OE)
		else $error("power good high on no-processor code");
	off_confirm_a: assert property ($rose(CONTROLLER_SHUTDOWN) |->
		same_cnt_reg >= 16'(OFF_CONFIRM_CYCLES) && IDENT_PINS == IDENT_OFF_CODE)
		else $error("shutdown before off code confirmed");
	blank_hold_a: assert property (steady_ok && $changed(IDENT_PINS) |->
		##6 ($stable(POWER_GOOD_OUT_OE) || !steady_ok)[*8])
		else $error("power good moved while blanked");
	slew_step_a: assert property ($changed(TARGET_LEVEL) && steady_ok |->
		TARGET_LEVEL == $past(TARGET_LEVEL) + 12'h001 ||
		TARGET_LEVEL == $past(TARGET_LEVEL) - 12'h001)
		else $error("target moved by more than one step");
	slew_gap_a: assert property ($changed(TARGET_LEVEL) && steady_ok |=>
		($stable(TARGET_LEVEL) || !steady_ok)[*8])
		else $error("target steps too close together");
endmodule : vid_ctrl_properties

bind vid_target_and_power_good_control vid_ctrl_properties #(.BLANK_CYCLES(BLANK_CYCLES)) chk (
	.CLK, .RST_N, .IDENT_PINS, .LOW_POWER_STATE_N, .ENABLE, .SUPPLY_OK, .LOAD_STEP_UP,
	.TARGET_LEVEL, .PHASE_ENABLE, .BASE_PHASE_DISABLE_N, .SWITCHED_PHASE_DISABLE_N,
	.CONTROLLER_SHUTDOWN, .POWER_GOOD_OUT_OE);

`default_nettype wire

//--- sim/vid_target_and_power_good_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module vid_target_and_power_good_control_tb
	import vid_ctrl_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] want_code;
	logic [7:0] pins;
	logic lp_n;
	logic en;
	logic sup_ok;
	logic [11:0] out_level;
	logic [11:0] off;
	logic step_up;
	logic rel;
	logic [11:0] target;
	logic [3:0] phases;
	logic base_n;
	logic shed_n;
	logic transient_detect_out;
	logic shut;
	logic clamp;
	logic pg_o;
	logic pg_oe;
	logic pg_pin;
	logic [7:0] map_a [10];
	logic [7:0] map_v [10];
	logic [27:0] ofs_tab [4];
	int bad_count;
	int n_compared;
	int i;

	// Pull-up on the open-drain power-good pin
	assign pg_pin = pg_oe ? pg_o : 1'b1;
	// Plant: output follows target plus a test offset
	always @(negedge clk) begin
		out_level <= target + off;
	end

	host_pins_model host (.clk(clk), .want_code(want_code), .pins(pins));

	vid_target_and_power_good_control #(.BLANK_CYCLES(18'h00032), .TURN_ON_DELAY(18'h00014)) dut (
		.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .IDENT_PINS(pins),
		.LOW_POWER_STATE_N(lp_n), .ENABLE(en), .SUPPLY_OK(sup_ok), .OUT_LEVEL(out_level),
		.LOAD_STEP_UP(step_up), .LOAD_RELEASE(rel), .TARGET_LEVEL(target),
		.PHASE_ENABLE(phases), .BASE_PHASE_DISABLE_N(base_n),
		.SWITCHED_PHASE_DISABLE_N(shed_n), .TRANSIENT_DETECT_OUT(transient_detect_out), .CLAMP_ACTIVE(clamp),
		.CONTROLLER_SHUTDOWN(shut), .POWER_GOOD_OUT_O(pg_o), .POWER_GOOD_OUT_OE(pg_oe));

	// ----
	// Tasks
	// ----
	task automatic summarize();
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(12'(rvalid), 12'h001);
		chk(12'(rdata), 12'(e));
	endtask : rd_reg

	// Slew can take thousands of cycles, so the bound is generous
	task automatic wait_tgt(input logic [11:0] e);
		for (i = 0; i < 30000 && target !== e; i++) begin
			@(negedge clk);
		end
		chk(target, e);
		if (i == 30000) begin
			summarize();
		end
	endtask : wait_tgt

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#450000;
		bad_count++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		want_code = 8'h40;
		lp_n = 1'b1;
		en = 1'b0;
		sup_ok = 1'b0;
		step_up = 1'b0;
		rel = 1'b0;
		off = 12'h000;
		out_level = 12'h000;
		bad_count = 0;
		n_compared = 0;
		map_a = '{ADDR_TARGET_CODE, ADDR_PHASE_CFG, ADDR_REG_CFG_A, ADDR_REG_CFG_B,
			ADDR_TRANSITION, ADDR_TRIM, ADDR_CAL, ADDR_GOOD_UPPER, ADDR_GOOD_LOWER, 8'h55};
		map_v = '{RST_TARGET_CODE, RST_PHASE_CFG, RST_REG_CFG, RST_REG_CFG, RST_TRANSITION,
			RST_OFFSET, RST_OFFSET, RST_GOOD_UPPER, RST_GOOD_LOWER, 8'h00};
		ofs_tab = '{28'h1F0105F, 28'h3F21021, 28'h0822046, 28'h0000040};
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (int k = 0; k < 10; k++) begin
			rd_reg(map_a[k], map_v[k]);
			wr_reg(map_a[k], 8'h5A);
			rd_reg(map_a[k], (k == 9) ? 8'h00 : 8'h5A);
			wr_reg(map_a[k], map_v[k]);
		end
		wr_reg(ADDR_TRANSITION, 8'h07);
		en = 1'b1;
		sup_ok = 1'b1;
		cyc(100);
		chk(12'(pg_pin), 12'h000);
		wait_tgt(12'h040);
		cyc(5);
		chk(12'(pg_pin), 12'h000);
		cyc(40);
		chk(12'(pg_pin), 12'h001);
		chk(12'(phases), 12'h00F);
		rd_reg(ADDR_STATUS, 8'h61);
		for (int k = 0; k < 4; k++) begin
			wr_reg(ADDR_TRIM, ofs_tab[k][27:20]);
			wr_reg(ADDR_CAL, ofs_tab[k][19:12]);
			wait_tgt(ofs_tab[k][11:0]);
		end
		wr_reg(ADDR_TARGET_CODE, 8'h50);
		wr_reg(ADDR_REG_CFG_A, 8'h08);
		cyc(300);
		chk(target, 12'h040);
		wr_reg(ADDR_REG_CFG_B, 8'h08);
		wait_tgt(12'h050);
		wr_reg(ADDR_REG_CFG_A, 8'h00);
		wait_tgt(12'h040);
		want_code = 8'h3F;
		wait_tgt(12'h03F);
		off = 12'h02D;
		cyc(20);
		chk(12'(pg_pin), 12'h001);
		chk(12'(phases), 12'h00F);
		wr_reg(ADDR_GOOD_UPPER, 8'h01);
		cyc(10);
		chk(12'(pg_pin), 12'h000);
		chk(12'(phases), 12'h000);
		chk(12'(clamp), 12'h001);
		wr_reg(ADDR_GOOD_UPPER, 8'h00);
		// Plant has no crowbar pull-down, so drop the output below release by hand
		off = 12'hFD0;
		cyc(20);
		chk(12'(clamp), 12'h000);
		chk(12'(phases), 12'h00F);
		off = 12'hFEC;
		cyc(10);
		off = 12'hFE2;
		cyc(30);
		chk(12'(pg_pin), 12'h001);
		wr_reg(ADDR_GOOD_LOWER, 8'h07);
		cyc(10);
		chk(12'(pg_pin), 12'h000);
		wr_reg(ADDR_GOOD_LOWER, 8'h00);
		off = 12'h000;
		lp_n = 1'b0;
		cyc(20);
		chk(12'(shed_n), 12'h000);
		chk(12'(phases), 12'h001);
		wr_reg(ADDR_PHASE_CFG, 8'h43);
		cyc(10);
		chk(12'(phases), 12'h005);
		lp_n = 1'b1;
		cyc(20);
		chk(12'(phases), 12'h00F);
		rel = 1'b1;
		cyc(6);
		chk(12'(transient_detect_out), 12'h001);
		rel = 1'b0;
		want_code = IDENT_NO_CPU_CODE;
		cyc(200);
		chk(12'(pg_pin), 12'h000);
		want_code = IDENT_OFF_CODE;
		cyc(900);
		chk(12'(shut), 12'h000);
		cyc(250);
		chk(12'(shut), 12'h001);
		en = 1'b0;
		cyc(10);
		chk({8'h00, pg_pin, base_n, shed_n, shut}, 12'h000);
		chk(12'(phases), 12'h000);
		summarize();
	end
endmodule : vid_target_and_power_good_control_tb

`default_nettype wire
